// ===== rtl/async_timer.v
`timescale 1ns/100ps
`include "timer_map.vh"
module async_timer (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata_ff,
    output reg         hreadyout_ff,
    output reg         hresp_ff,
    input  wire        sosc_clk_in,
    input  wire        external_clock_pin,
    input  wire        low_power_rc_oscillator,
    input  wire        gate_pin,
    input  wire        cpu_idle,
    input  wire        cpu_sleep,
    output reg         timer_event_ff
);
    localparam [1:0] SEL_CTRL   = 2'd0;
    localparam [1:0] SEL_COUNT  = 2'd1;
    localparam [1:0] SEL_PERIOD = 2'd2;
    localparam [1:0] SEL_NONE   = 2'd3;

    reg  [15:0] ctrl_ff;
    reg  [15:0] count_ff;
    reg  [15:0] period_ff;
    reg  [15:0] pend_val_ff;
    reg         pending_ff;
    reg  [7:0]  pre_cnt_ff;
    reg         dp_wr_ff;
    reg  [1:0]  dp_sel_ff;
    reg  [1:0]  dp_op_ff;

    reg  [15:0] nxt_ctrl;
    reg  [15:0] nxt_count;
    reg  [15:0] nxt_period;
    reg  [15:0] nxt_pend_val;
    reg         nxt_pending;
    reg  [7:0]  nxt_pre_cnt;
    reg         tick;
    reg  [7:0]  pre_term;
    reg         ext_rise;
    reg  [1:0]  addr_sel;
    reg  [31:0] rd_word;

    wire        sosc_rise;
    wire        pin_rise;
    wire        low_power_rc_oscillator_rise;
    wire        gate_level;
    wire        gate_fall;

    ////////////////////////////////////////////////////////////////////
    // external inputs, each through its own synchroniser
    pin_sync u_sosc (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (sosc_clk_in),
        .level_ff (),
        .rise_ff  (sosc_rise),
        .fall_ff  ()
    );
    pin_sync u_pin (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (external_clock_pin),
        .level_ff (),
        .rise_ff  (pin_rise),
        .fall_ff  ()
    );
    pin_sync u_low_power_rc_oscillator (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (low_power_rc_oscillator),
        .level_ff (),
        .rise_ff  (low_power_rc_oscillator_rise),
        .fall_ff  ()
    );
    pin_sync u_gate (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (gate_pin),
        .level_ff (gate_level),
        .rise_ff  (),
        .fall_ff  (gate_fall)
    );

    ////////////////////////////////////////////////////////////////////
    // control decode
    wire        on_bit    = ctrl_ff[`CTL_ON];
    wire        ext_sel   = ctrl_ff[`CTL_CS];
    wire        gate_en   = ctrl_ff[`CTL_GATE] & ~ext_sel;
    wire        async_md  = ext_sel & ~ctrl_ff[`CTL_SYNC];
    wire        wblock    = ctrl_ff[`CTL_WBLOCK];
    wire [1:0]  ecs       = ctrl_ff[`CTL_ECS_HI:`CTL_ECS_LO];
    wire [1:0]  pre_sel   = ctrl_ff[`CTL_PRE_HI:`CTL_PRE_LO];
    // internal clock stops in sleep; an external source keeps going
    wire        run       = on_bit
                          & ~(cpu_idle & ctrl_ff[`CTL_IDLE_STOP])
                          & ~(cpu_sleep & ~ext_sel);
    wire        gate_ok   = ~gate_en | gate_level;
    wire        src_edge  = ext_sel ? ext_rise : 1'b1;
    wire        match     = (count_ff == period_ff);
    wire        bus_acc   = hsel & htrans[1] & hready;
    wire        wr_go     = dp_wr_ff;
    wire [15:0] wdat      = hwdata[15:0];

    ////////////////////////////////////////////////////////////////////
    // alias write: plain, clear, set or toggle the written ones
    function [15:0] apply_op;
        input [15:0] old;
        input [15:0] wd;
        input [1:0]  op;
        begin
            case (op)
                `OP_CLEAR:  apply_op = old & ~wd;
                `OP_SET:    apply_op = old | wd;
                `OP_INVERT: apply_op = old ^ wd;
                default:    apply_op = wd;
            endcase
        end
    endfunction

    wire [15:0] cnt_wval  = apply_op(count_ff, wdat, dp_op_ff);
    wire        cnt_wr    = wr_go & (dp_sel_ff == SEL_COUNT);
    wire        xfer      = pending_ff & ext_rise;
    // a blocked write while pending is simply dropped
    wire        accept    = cnt_wr & async_md
                          & ~(wblock & pending_ff);

    ////////////////////////////////////////////////////////////////////
    // external source and prescale selection
    always @* begin
        case (ecs)
            `ECS_SOSC: ext_rise = sosc_rise;
            `ECS_PIN:  ext_rise = pin_rise;
            `ECS_LOW_POWER_RC_OSCILLATOR: ext_rise = low_power_rc_oscillator_rise;
            default:   ext_rise = 1'b0;  // reserved code never ticks
        endcase
        case (pre_sel)
            2'd1:    pre_term = `PRE_TERM_8;
            2'd2:    pre_term = `PRE_TERM_64;
            2'd3:    pre_term = `PRE_TERM_256;
            default: pre_term = `PRE_TERM_1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // prescaler and counter next state
    always @* begin
        tick        = 1'b0;
        nxt_pre_cnt = pre_cnt_ff;
        if (!run) begin
            nxt_pre_cnt = 8'h00;
        end else if (src_edge && gate_ok) begin
            if (pre_cnt_ff >= pre_term) begin
                nxt_pre_cnt = 8'h00;
                tick        = 1'b1;
            end else begin
                nxt_pre_cnt = pre_cnt_ff + 8'h01;
            end
        end
        nxt_count = count_ff;
        if (cnt_wr && !async_md) begin
            nxt_count = cnt_wval;
        end else if (xfer) begin
            nxt_count = pend_val_ff;
        end else if (tick) begin
            nxt_count = match ? 16'h0000 : count_ff + 16'h0001;
        end
        // a new write wins over the transfer that ends the old one
        nxt_pending  = pending_ff;
        nxt_pend_val = pend_val_ff;
        if (accept) begin
            nxt_pending  = 1'b1;
            nxt_pend_val = cnt_wval;
        end else if (xfer || !async_md) begin
            nxt_pending  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control and period next state
    always @* begin
        nxt_ctrl   = ctrl_ff;
        nxt_period = period_ff;
        if (wr_go && dp_sel_ff == SEL_CTRL) begin
            nxt_ctrl = apply_op(ctrl_ff, wdat, dp_op_ff)
                     & `CTRL_WMASK;
        end
        if (wr_go && dp_sel_ff == SEL_PERIOD) begin
            nxt_period = apply_op(period_ff, wdat, dp_op_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // address decode; the alias lanes share the base register
    always @* begin
        case ({4'h0, haddr[11:4]})
            `REG_CTRL_OFS >> 4:   addr_sel = SEL_CTRL;
            `REG_COUNT_OFS >> 4:  addr_sel = SEL_COUNT;
            `REG_PERIOD_OFS >> 4: addr_sel = SEL_PERIOD;
            default:              addr_sel = SEL_NONE;
        endcase
        // read from next state so a write just before is seen at once
        case (addr_sel)
            SEL_CTRL: begin
                rd_word = {16'h0000, nxt_ctrl};
                rd_word[`CTL_WPEND] = nxt_pending & nxt_ctrl[`CTL_CS]
                                    & ~nxt_ctrl[`CTL_SYNC];
            end
            SEL_COUNT:  rd_word = {16'h0000, nxt_count};
            SEL_PERIOD: rd_word = {16'h0000, nxt_period};
            default:    rd_word = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // bus slave: zero wait, always okay, word writes only
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr_ff     <= 1'b0;
            dp_sel_ff    <= SEL_NONE;
            dp_op_ff     <= `OP_WRITE;
            hrdata_ff    <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
            dp_wr_ff     <= bus_acc & hwrite & (hsize == 3'b010)
                          & (addr_sel != SEL_NONE);
            dp_sel_ff    <= addr_sel;
            dp_op_ff     <= haddr[3:2];
            if (bus_acc && !hwrite) begin
                hrdata_ff <= rd_word;
            end else begin
                hrdata_ff <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // timer state registers
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff        <= `CTRL_RST;
            count_ff       <= `COUNT_RST;
            period_ff      <= `PERIOD_RST;
            pend_val_ff    <= `COUNT_RST;
            pending_ff     <= 1'b0;
            pre_cnt_ff     <= 8'h00;
            timer_event_ff <= 1'b0;
        end else begin
            ctrl_ff        <= nxt_ctrl;
            count_ff       <= nxt_count;
            period_ff      <= nxt_period;
            pend_val_ff    <= nxt_pend_val;
            pending_ff     <= nxt_pending;
            pre_cnt_ff     <= nxt_pre_cnt;
            // one-cycle event on wrap or on end of a gate window
            timer_event_ff <= (tick & match & ~cnt_wr & ~xfer)
                            | (gate_en & on_bit & gate_fall);
        end
    end
endmodule // async_timer

// ===== pkg/timer_map.vh
// Summary of operation
// - Control bit 15 turns the timer on when set and halts it when clear.
// - With control bit 13 set the timer stops while the device idles.
// - With bit 12 set, count writes are dropped while one is pending.
// - In asynchronous mode bit 11 reads 1 while a count write is pending.
// - In synchronous mode the write-pending bit always reads 0.
// - Bits 9-8 pick the external source: 00 sosc, 01 pin, 10 low_power_rc_oscillator.
// - Bit 7 enables gated accumulation, only with the internal clock.
// - Bits 5-4 set the prescale to 1, 8, 64 or 256.
// - Bit 2 picks a synchronised external input, ignored when internal.
// - Bit 1 picks the internal clock at 0, the external source at 1.
// - Control bits 31-16, 14, 10, 6, 3 and 0 always read as zero.
// - Offsets 0x4, 0x8 and 0xC clear, set or toggle the written ones.
// - The timer keeps running in idle and sleep when so configured.
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// register byte offsets, low address bits
`define REG_CTRL_OFS     12'h600
`define REG_COUNT_OFS    12'h610
`define REG_PERIOD_OFS   12'h620

// alias operations from address bits 3:2
`define OP_WRITE         2'h0
`define OP_CLEAR         2'h1
`define OP_SET           2'h2
`define OP_INVERT        2'h3

// control field positions
`define CTL_ON           15
`define CTL_IDLE_STOP    13
`define CTL_WBLOCK       12
`define CTL_WPEND        11
`define CTL_ECS_HI       9
`define CTL_ECS_LO       8
`define CTL_GATE         7
`define CTL_PRE_HI       5
`define CTL_PRE_LO       4
`define CTL_SYNC         2
`define CTL_CS           1

// writable control bits and reset values
`define CTRL_WMASK       16'hb3b6
`define CTRL_RST         16'h0000
`define COUNT_RST        16'h0000
`define PERIOD_RST       16'hffff

// prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define PRE_TERM_1       8'h00
`define PRE_TERM_8       8'h07
`define PRE_TERM_64      8'h3f
`define PRE_TERM_256     8'hff

// external source codes
`define ECS_SOSC         2'h0
`define ECS_PIN          2'h1
`define ECS_LOW_POWER_RC_OSCILLATOR         2'h2

`endif

// ===== rtl/pin_sync.v
`timescale 1ns/100ps
module pin_sync (
    input  wire core_clk,
    input  wire rst_n,
    input  wire pin_in,
    output reg  level_ff,
    output reg  rise_ff,
    output reg  fall_ff
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;

    ////////////////////////////////////////////////////////////////////
    // three stages; a change counts once stages two and three agree
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff    <= 1'b0;
            s2_ff    <= 1'b0;
            s3_ff    <= 1'b0;
            level_ff <= 1'b0;
            rise_ff  <= 1'b0;
            fall_ff  <= 1'b0;
        end else begin
            s1_ff   <= pin_in;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
            // filters single-sample glitches on slow pins
            if (s2_ff == s3_ff && s3_ff != level_ff) begin
                level_ff <= s3_ff;
                rise_ff  <= s3_ff;
                fall_ff  <= ~s3_ff;
            end
        end
    end
endmodule // pin_sync

// ===== test/async_timer_asserts.sv
`timescale 1ns/100ps
module async_timer_asserts (
    input logic        core_clk,
    input logic        rst_n,
    input logic        hsel,
    input logic [31:0] haddr,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic [2:0]  hsize,
    input logic [31:0] hwdata,
    input logic        hready,
    input logic [31:0] hrdata_ff,
    input logic        hreadyout_ff,
    input logic        hresp_ff,
    input logic        timer_event_ff
);
    logic       ctl_wr_ff;
    logic [1:0] ctl_op_ff;
    logic       on_ff;
    logic       nxt_on;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // shadow of the on bit, aliases included, so off can be judged here
    assign nxt_on = (ctl_op_ff == 2'h0) ? hwdata[15] :
                    (ctl_op_ff == 2'h1) ? on_ff & ~hwdata[15] :
                    (ctl_op_ff == 2'h2) ? on_ff | hwdata[15] :
                    on_ff ^ hwdata[15];
    // address phase captured, data phase applied
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_wr_ff <= 1'b0;
            ctl_op_ff <= 2'h0;
            on_ff     <= 1'b0;
        end else begin
            ctl_wr_ff <= hsel && htrans[1] && hready && hwrite &&
                         hsize == 3'h2 && haddr[11:4] == 8'h60;
            ctl_op_ff <= haddr[3:2];
            if (ctl_wr_ff)
                on_ff <= nxt_on;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // read address phases
    sequence s_rd;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_rd_ctrl;
        s_rd ##0 haddr[11:4] == 8'h60;
    endsequence
    sequence s_rd_data;
        s_rd ##0 (haddr[11:4] == 8'h61 || haddr[11:4] == 8'h62);
    endsequence
    sequence s_rd_hole;
        s_rd ##0 (haddr[11:4] > 8'h62 || haddr[11:4] < 8'h60);
    endsequence
    property p_ready;
        hreadyout_ff;
    endproperty
    property p_okay;
        !hresp_ff;
    endproperty
    property p_rest;
        !(hsel && htrans[1] && hready && !hwrite) |=> hrdata_ff == 32'h0;
    endproperty
    property p_ctl_unused;
        s_rd_ctrl |=> (hrdata_ff & ~32'h0000_bbb6) == 32'h0;
    endproperty
    property p_sync_wpend;
        s_rd_ctrl |=> !hrdata_ff[11] || (hrdata_ff[1] && !hrdata_ff[2]);
    endproperty
    property p_data_upper;
        s_rd_data |=> hrdata_ff[31:16] == 16'h0;
    endproperty
    property p_hole;
        s_rd_hole |=> hrdata_ff == 32'h0;
    endproperty
    // event is registered, so allow it to drain after on drops
    property p_off_quiet;
        !on_ff [*4] |-> !timer_event_ff;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready dropped");
    a_okay: assert property (p_okay)
        else $error("error response");
    a_rest: assert property (p_rest)
        else $error("read data outside data phase");
    a_ctl_unused: assert property (p_ctl_unused)
        else $error("unused control bit set");
    a_sync_wpend: assert property (p_sync_wpend)
        else $error("pending seen in sync mode");
    a_data_upper: assert property (p_data_upper)
        else $error("upper half not zero");
    a_hole: assert property (p_hole)
        else $error("hole read not zero");
    a_off_quiet: assert property (p_off_quiet)
        else $error("event while off");
endmodule // async_timer_asserts

bind async_timer async_timer_asserts u_asserts (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff),
    .hresp_ff(hresp_ff), .timer_event_ff(timer_event_ff)
);

// ===== test/async_timer_tb.sv
`timescale 1ns/100ps
module async_timer_tb;
    logic        core_clk, rst_n, hsel, hwrite, gate_pin, cpu_idle, cpu_sleep;
    logic [31:0] haddr, hwdata, rd, r1, m, a;
    logic [1:0]  htrans;
    logic [2:0]  hsize, ext;
    wire  [31:0] hrdata_ff;
    wire         hreadyout_ff, hresp_ff, timer_event_ff;
    integer      n_mismatch = 0, n_checks = 0, i, j, n;
    integer      seed = 32'h7429_0a4f;

    async_timer uut (
        .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout_ff), .hrdata_ff(hrdata_ff),
        .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
        .sosc_clk_in(ext[0]), .external_clock_pin(ext[1]),
        .low_power_rc_oscillator(ext[2]), .gate_pin(gate_pin),
        .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
        .timer_event_ff(timer_event_ff)
    );
    ////////////////////////////////////////////////////////////////////////
    // 20 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // a hang costs a mismatch; the longest span is 1280 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch = n_mismatch + 1;
        final_report;
    end
    task final_report;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp, input string what);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    // one ahb-lite single word transfer, entered just after an edge
    task bus(input [31:0] adr, input w, input [31:0] wd);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= adr;
            hwrite <= w;
            @(posedge core_clk);
            while (hreadyout_ff !== 1'b1) @(posedge core_clk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            @(posedge core_clk);
            while (hreadyout_ff !== 1'b1) @(posedge core_clk);
            rd = hrdata_ff;
        end
    endtask
    task rdc(input [31:0] adr, input [31:0] exp, input string what);
        begin
            bus(adr, 1'b0, 32'h0000_0000);
            chk(rd, exp, what);
        end
    endtask
    // cycles from one event pulse to the next
    task span(output integer c);
        begin
            while (timer_event_ff !== 1'b1) @(posedge core_clk);
            @(posedge core_clk);
            c = 1;
            while (timer_event_ff !== 1'b1) begin
                @(posedge core_clk);
                c = c + 1;
            end
        end
    endtask
    // slow pulses, long enough for the three-flop synchroniser
    task pulse(input [1:0] s, input integer k);
        repeat (k) begin
            ext[s] <= 1'b1;
            repeat (4) @(posedge core_clk);
            ext[s] <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask
    function [31:0] alias_fn(input [31:0] v, input [31:0] mk, input int op);
        case (op)
            1: alias_fn = v & ~mk & 32'h0000_ffff;
            2: alias_fn = (v | mk) & 32'h0000_ffff;
            default: alias_fn = (v ^ mk) & 32'h0000_ffff;
        endcase
    endfunction
    function integer div_fn(input integer code);
        div_fn = (code == 0) ? 1 : (code == 1) ? 8 : (code == 2) ? 64 : 256;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        ext = 3'h0;
        gate_pin = 1'b0;
        cpu_idle = 1'b0;
        cpu_sleep = 1'b0;
        rst_n = 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rdc(32'h0000_0600, 32'h0000_0000, "ctrl");
        rdc(32'h0000_0610, 32'h0000_0000, "count");
        rdc(32'h0000_0620, 32'h0000_ffff, "period");
        rdc(32'h0000_0630, 32'h0000_0000, "hole");
        // all ones selects the reserved source, so nothing ticks
        bus(32'h0000_0600, 1'b1, 32'hffff_ffff);
        rdc(32'h0000_0600, 32'h0000_b3b6, "ctrl mask");
        bus(32'h0000_0600, 1'b1, 32'h0000_0000);
        for (i = 0; i < 6; i = i + 1) begin
            a = 32'h0000_0610 + 32'(i / 3) * 32'h0000_0010;
            r1 = $random(seed);
            m = $random(seed);
            bus(a, 1'b1, r1);
            bus(a + 32'(i % 3 + 1) * 32'h0000_0004, 1'b1, m);
            rdc(a, alias_fn(r1, m, i % 3 + 1), "alias");
        end
        // count cleared first, or it would run the long way round
        bus(32'h0000_0610, 1'b1, 32'h0000_0000);
        for (j = 0; j < 4; j = j + 1) begin
            bus(32'h0000_0620, 1'b1, 32'(j + 1));
            bus(32'h0000_0600, 1'b1, 32'h0000_8000 | 32'(j << 4));
            span(n);
            span(n);
            chk(n, (j + 2) * div_fn(j), "wrap span");
        end
        bus(32'h0000_0604, 1'b1, 32'h0000_8000);
        repeat (2) @(posedge core_clk);
        bus(32'h0000_0610, 1'b0, 32'h0000_0000);
        r1 = rd;
        repeat (30) @(posedge core_clk);
        rdc(32'h0000_0610, r1, "halted");
        bus(32'h0000_0620, 1'b1, 32'h0000_ffff);
        bus(32'h0000_0600, 1'b1, 32'h0000_a000);
        cpu_idle <= 1'b1;
        bus(32'h0000_0610, 1'b0, 32'h0000_0000);
        r1 = rd;
        repeat (20) @(posedge core_clk);
        rdc(32'h0000_0610, r1, "idle stop");
        bus(32'h0000_0604, 1'b1, 32'h0000_2000);
        bus(32'h0000_0610, 1'b0, 32'h0000_0000);
        r1 = rd;
        repeat (20) @(posedge core_clk);
        rdc(32'h0000_0610, r1 + 32'h0000_0016, "idle run");
        cpu_idle <= 1'b0;
        bus(32'h0000_0600, 1'b1, 32'h0000_8080);
        bus(32'h0000_0610, 1'b0, 32'h0000_0000);
        r1 = rd;
        repeat (20) @(posedge core_clk);
        rdc(32'h0000_0610, r1, "gate low");
        gate_pin <= 1'b1;
        repeat (10) @(posedge core_clk);
        gate_pin <= 1'b0;
        n = 0;
        while (timer_event_ff !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            n = n + 1;
        end
        chk({31'h0, timer_event_ff}, 32'h0000_0001, "gate fall");
        // external sources keep counting through sleep
        cpu_sleep <= 1'b1;
        for (j = 0; j < 4; j = j + 1) begin
            bus(32'h0000_0600, 1'b1, 32'h0000_8006 | 32'(j << 8));
            bus(32'h0000_0610, 1'b1, 32'h0000_0000);
            pulse((j == 3) ? 2'h0 : j[1:0], 5);
            repeat (6) @(posedge core_clk);
            n = (j == 3) ? 0 : 5;
            rdc(32'h0000_0610, n, "ext");
        end
        // the internal clock stops in sleep, so the count must hold
        bus(32'h0000_0600, 1'b1, 32'h0000_8000);
        bus(32'h0000_0610, 1'b0, 32'h0000_0000);
        r1 = rd;
        repeat (10) @(posedge core_clk);
        rdc(32'h0000_0610, r1, "sleep stop");
        cpu_sleep <= 1'b0;
        bus(32'h0000_0600, 1'b1, 32'h0000_9102);
        bus(32'h0000_0610, 1'b0, 32'h0000_0000);
        r1 = rd;
        m = $random(seed) & 32'h0000_ffff;
        bus(32'h0000_0610, 1'b1, m);
        rdc(32'h0000_0600, 32'h0000_9902, "pending");
        bus(32'h0000_0610, 1'b1, 32'h0000_5555);
        rdc(32'h0000_0610, r1, "held");
        pulse(2'h1, 1);
        rdc(32'h0000_0610, m, "loaded");
        rdc(32'h0000_0600, 32'h0000_9102, "done");
        bus(32'h0000_0604, 1'b1, 32'h0000_1000);
        bus(32'h0000_0610, 1'b1, 32'h0000_1111);
        bus(32'h0000_0610, 1'b1, 32'h0000_2222);
        pulse(2'h1, 1);
        rdc(32'h0000_0610, 32'h0000_2222, "back to back");
        final_report;
    end
endmodule // async_timer_tb
